// ==== hdl/dtt_top.sv ====
// dram timing turnaround configuration register and gap enforcement
// assumes a single-cycle register port and a scheduler on the same clock
//
// The address-and-strobe port was chosen for this implementation.
`include "dtt_params.svh"
module dtt_top
  import dtt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // scheduler command events, one-cycle pulses
  input  wire logic        sch_rd_i,
  input  wire logic        sch_wr_i,
  input  wire logic        sch_ref_i,
  input  wire logic        sch_new_rank_i,
  // scheduler grants and settings
  output logic             rd_ok_o,
  output logic             wr_ok_o,
  output logic             ref_busy_o,
  output logic      [1:0]  rdptr_dly_o
);
  logic [31:0] timing_q;              // dram_timing register
  logic [1:0]  freq_q;                // command clock selection
  logic [31:0] rdata_q;               // read data register
  logic [4:0]  gap_q, gap_d;          // data bus gap down-counter
  logic [4:0]  ref_q, ref_d;          // refresh busy down-counter
  logic        rd_ok_q, wr_ok_q;      // registered grants
  logic [1:0]  rdptr_q;               // registered pointer delay
  logic [1:0]  rdptr_clk, wrrd_clk, rdrd_clk;
  logic [2:0]  rdwr_clk;
  logic [4:0]  trfc_clk, bad;
  logic        last_rd_q, last_rd_d;  // last bus transfer was a read
  wire  [1:0]  rdptr_code = timing_q[`DTT_RDPTR_MSB:`DTT_RDPTR_LSB]; // raw delay code

  // saturating count-down shared by the three gap counters
  function automatic logic [4:0] sat_dec(input logic [4:0] v);
    return (v != 5'h0) ? v - 5'h1 : 5'h0;
  endfunction

  dtt_decode u_dec (
    .rdptr_i     (timing_q[`DTT_RDPTR_MSB:`DTT_RDPTR_LSB]),
    .wrrd_i      (timing_q[`DTT_WRRD_MSB:`DTT_WRRD_LSB]),
    .rdwr_i      (timing_q[`DTT_RDWR_MSB:`DTT_RDWR_LSB]),
    .rdrd_i      (timing_q[`DTT_RDRD_MSB:`DTT_RDRD_LSB]),
    .trfc_i      (timing_q[`DTT_TRFC_MSB:`DTT_TRFC_LSB]),
    .freq_i      (freq_q),
    .rdptr_clk_o (rdptr_clk),
    .wrrd_clk_o  (wrrd_clk),
    .rdwr_clk_o  (rdwr_clk),
    .rdrd_clk_o  (rdrd_clk),
    .trfc_clk_o  (trfc_clk),
    .bad_o       (bad)
  );

  // address decode
  wire sel_tim  = (addr_i == `DTT_DRAM_TIMING_OFS);
  wire sel_freq = (addr_i == `DTT_FREQ_OFS);
  wire sel_stat = (addr_i == `DTT_STAT_OFS);
  wire [31:0] rd_mux = sel_tim  ? timing_q :
                       sel_freq ? {30'h0, freq_q} :
                       sel_stat ? {27'h0, bad} : 32'h0;

  // register writes; reserved timing codes are stored but flagged for software, frequency code 3 is dropped
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timing_q <= `DTT_DRAM_TIMING_RST;
      freq_q   <= `DTT_FREQ_RST;
    end else if (wr_i && sel_tim) begin
      timing_q <= wdata_i;
    end else if (wr_i && sel_freq) begin
      freq_q   <= (wdata_i[1:0] == 2'h3) ? freq_q : wdata_i[1:0];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rdata_q <= 32'h0;
    else           rdata_q <= rd_i ? rd_mux : 32'h0;
  end

  // last data bus transfer type, for choosing the gap
  wire rd_evt = sch_rd_i;
  wire wr_evt = sch_wr_i && !sch_rd_i;

  // gap counter: loads the count owed to the next opposite command
  always_comb begin
    gap_d = sat_dec(gap_q);
    if (wr_evt)
      gap_d = sch_new_rank_i ? {3'h0, wrrd_clk} : 5'h0;
    else if (rd_evt)
      gap_d = {2'h0, rdwr_clk};
  end

  // remembers which kind of gap is pending; the event of this cycle must
  // already steer the grant, or the first cycle of every gap leaks through
  assign last_rd_d = rd_evt ? 1'b1 : (wr_evt ? 1'b0 : last_rd_q);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) last_rd_q <= 1'b0;
    else           last_rd_q <= last_rd_d;
  end

  // read-to-read rank gap uses its own shorter count
  logic [4:0] rr_q, rr_d;
  always_comb begin
    rr_d = sat_dec(rr_q);
    if (rd_evt) rr_d = {3'h0, rdrd_clk};
  end

  // refresh busy counter
  always_comb begin
    ref_d = sat_dec(ref_q);
    if (sch_ref_i) ref_d = trfc_clk;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_q <= 5'h0;
      rr_q  <= 5'h0;
      ref_q <= 5'h0;
    end else begin
      gap_q <= gap_d;
      rr_q  <= rr_d;
      ref_q <= ref_d;
    end
  end

  // grants: counters at zero free the bus; a read waits on rdrd after any read, never on rdwr
  // a refresh blocks both kinds; the gap counter only blocks the opposite kind
  wire rd_free = (ref_d == 5'h0) && (last_rd_d ? 1'b1 : (gap_d == 5'h0));
  wire wr_free = (ref_d == 5'h0) && (last_rd_d ? (gap_d == 5'h0) : 1'b1);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_ok_q <= 1'b1;
      wr_ok_q <= 1'b1;
      rdptr_q <= 2'h0;
    end else begin
      rd_ok_q <= rd_free && (rr_d == 5'h0);
      wr_ok_q <= wr_free;
      rdptr_q <= rdptr_clk;
    end
  end

  assign rdata_o     = rdata_q;
  assign rd_ok_o     = rd_ok_q;
  assign wr_ok_o     = wr_ok_q;
  assign rdptr_dly_o = rdptr_q;
  logic ref_busy_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) ref_busy_q <= 1'b0;
    else           ref_busy_q <= (ref_d != 5'h0);
  end
  assign ref_busy_o = ref_busy_q;

  // checks
  property p_rdwr_gap;
    @(posedge clk_i) disable iff (sys_rst_i)
    sch_rd_i |=> !wr_ok_o;
  endproperty
  a_rdwr_gap: assert property (p_rdwr_gap) else $error("write granted inside gap");

  property p_ref_busy;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sch_ref_i && trfc_clk == `DTT_TRFC10_133) |=> ref_busy_o [*8];
  endproperty
  a_ref_busy: assert property (p_ref_busy) else $error("refresh busy dropped early");

  property p_rdptr;
    @(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> (rdptr_dly_o != 2'h3);
  endproperty
  a_rdptr: assert property (p_rdptr) else $error("pointer delay reserved");

  property p_wrrd;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sch_wr_i && !sch_rd_i && !sch_ref_i && sch_new_rank_i && wrrd_clk != 2'h0)
      |=> !rd_ok_o;
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("read granted inside bubble");

  property p_rdrd;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sch_rd_i && rdrd_clk != 2'h0) |=> !rd_ok_o;
  endproperty
  a_rdrd: assert property (p_rdrd) else $error("read granted inside rank gap");

  property p_reg;
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && sel_tim) ##1 (rd_i && sel_tim) |=> (rdata_o == $past(wdata_i, 2));
  endproperty
  a_reg: assert property (p_reg) else $error("timing register readback wrong");

  // a refresh must hold off both grants, not only raise busy
  property p_ref_block;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sch_ref_i && trfc_clk != 5'h0) |=> (ref_busy_o && !rd_ok_o && !wr_ok_o);
  endproperty
  a_ref_block: assert property (p_ref_block) else $error("grant in refresh");

  // read data must not linger past its one cycle
  property p_rd_idle;
    @(posedge clk_i) disable iff (sys_rst_i)
    !rd_i |=> (rdata_o == 32'h0);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

  // each defined pointer code gives that many clocks
  property p_rdptr_code;
    @(posedge clk_i) disable iff (sys_rst_i)
    (rdptr_code != 2'h3) |=> (rdptr_dly_o == $past(rdptr_code));
  endproperty
  a_rdptr_code: assert property (p_rdptr_code) else $error("bad delay");

  // a write to the same rank adds no bubble before the next read
  property p_wr_same;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sch_wr_i && !sch_rd_i && !sch_ref_i && !sch_new_rank_i &&
     ref_q <= 5'h1 && rr_q <= 5'h1) |=> rd_ok_o;
  endproperty
  a_wr_same: assert property (p_wr_same) else $error("needless bubble");
endmodule

// ==== hdl/dtt_params.svh ====
// constants of the dram timing turnaround configuration block
// assumes inclusion by hdl/dtt_pkg.sv and the design modules
`ifndef DTT_PARAMS_SVH
`define DTT_PARAMS_SVH
`define DTT_DRAM_TIMING_OFS  8'h78
`define DTT_DRAM_TIMING_RST  32'h9599_9604
`define DTT_RDPTR_MSB        31
`define DTT_RDPTR_LSB        30
`define DTT_WRRD_MSB         29
`define DTT_WRRD_LSB         28
`define DTT_RDWR_MSB         27
`define DTT_RDWR_LSB         26
`define DTT_RDRD_MSB         25
`define DTT_RDRD_LSB         24
`define DTT_TRFC_MSB         23
`define DTT_TRFC_LSB         22
`define DTT_FREQ_OFS         8'h7C
`define DTT_STAT_OFS         8'h80
`define DTT_FREQ_RST         2'h2
`define DTT_TRFC00_133       5'h0A
`define DTT_TRFC00_167       5'h0C
`define DTT_TRFC00_200       5'h0F
`define DTT_TRFC10_133       5'h10
`define DTT_TRFC10_167       5'h14
`define DTT_TRFC10_200       5'h1A
`define DTT_TRFC01_200       5'h15
`endif

// ==== hdl/dtt_pkg.sv ====
// types of the dram timing turnaround configuration block
// assumes dtt_params.svh is on the include path
`include "dtt_params.svh"
package dtt_pkg;
  // command clock frequency selection
  typedef enum logic [1:0] {
    DTT_F133 = 2'h0,
    DTT_F167 = 2'h1,
    DTT_F200 = 2'h2
  } dtt_freq_t;
endpackage

// ==== hdl/dtt_decode.sv ====
// decoder from timing field codes to command clock counts
// assumes codes and frequency come from registers on the same clock
`include "dtt_params.svh"
module dtt_decode
  import dtt_pkg::*;
(
  // field codes
  input  wire logic [1:0] rdptr_i,
  input  wire logic [1:0] wrrd_i,
  input  wire logic [1:0] rdwr_i,
  input  wire logic [1:0] rdrd_i,
  input  wire logic [1:0] trfc_i,
  input  wire logic [1:0] freq_i,
  // decoded counts and legality
  output logic      [1:0] rdptr_clk_o,
  output logic      [1:0] wrrd_clk_o,
  output logic      [2:0] rdwr_clk_o,
  output logic      [1:0] rdrd_clk_o,
  output logic      [4:0] trfc_clk_o,
  output logic      [4:0] bad_o
);
  // 200 MHz alone unlocks the 3-clock bubble codes
  wire is200 = (freq_i == DTT_F200);
  assign rdptr_clk_o = (rdptr_i == 2'h3) ? 2'h0 : rdptr_i;
  assign wrrd_clk_o  = wrrd_i;
  assign rdwr_clk_o  = {1'b0, rdwr_i} + 3'h1;
  assign rdrd_clk_o  = rdrd_i;
  // refresh cycle time table by code and frequency
  assign trfc_clk_o =
    (trfc_i == 2'h0) ? ((freq_i == DTT_F133) ? `DTT_TRFC00_133 :
                        (freq_i == DTT_F167) ? `DTT_TRFC00_167 : `DTT_TRFC00_200) :
    (trfc_i == 2'h2) ? ((freq_i == DTT_F133) ? `DTT_TRFC10_133 :
                        (freq_i == DTT_F167) ? `DTT_TRFC10_167 : `DTT_TRFC10_200) :
    (trfc_i == 2'h1 && is200) ? `DTT_TRFC01_200 : 5'h00;
  // one flag per field: code reserved at this frequency
  assign bad_o[0] = (rdptr_i == 2'h3);
  assign bad_o[1] = (wrrd_i == 2'h0) || (wrrd_i == 2'h3 && !is200);
  assign bad_o[2] = 1'b0;
  assign bad_o[3] = (rdrd_i == 2'h0) || (rdrd_i == 2'h3 && !is200);
  assign bad_o[4] = (trfc_i == 2'h3) || (trfc_i == 2'h1 && !is200);
endmodule

// ==== tb/dtt_sched_model.sv ====
// stand-in for the command scheduler that uses the timing settings
// assumes issue is called right after a rising clock edge
module dtt_sched_model (
  // clock
  input  wire logic clk_i,
  // command pulses towards the block
  output logic      sch_rd_o,
  output logic      sch_wr_o,
  output logic      sch_ref_o,
  output logic      new_rank_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet until the bench asks for a command
  initial begin
    sch_rd_o   = 1'b0;
    sch_wr_o   = 1'b0;
    sch_ref_o  = 1'b0;
    new_rank_o = 1'b0;
  end
  // one-cycle command, rank flag level with it; kind 0 read, 1 write, 2 refresh
  task automatic issue(input logic [1:0] kind, input logic nr);
    sch_rd_o   <= (kind == 2'h0);
    sch_wr_o   <= (kind == 2'h1);
    sch_ref_o  <= (kind == 2'h2);
    new_rank_o <= nr;
    @(posedge clk_i);
    sch_rd_o   <= 1'b0;
    sch_wr_o   <= 1'b0;
    sch_ref_o  <= 1'b0;
    new_rank_o <= 1'b0;
  endtask
endmodule

// ==== tb/dtt_top_bench.sv ====
// self-checking bench of the timing turnaround register block
// assumes dtt_sched_model stands in for the command scheduler
module dtt_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;      // 100 MHz clock
  logic        sys_rst_i = 1'b1;  // held two edges
  logic [7:0]  addr_i = 8'h00;    // register address
  logic [31:0] wdata_i = 32'h0;   // write data
  logic        wr_i = 1'b0;       // write strobe
  logic        rd_i = 1'b0;       // read strobe
  logic [31:0] rdata_o;           // read data
  logic        s_rd, s_wr, s_ref, s_nr; // scheduler pulses
  logic        rd_ok_o, wr_ok_o, ref_busy_o;
  logic [1:0]  rdptr_dly_o;       // read pointer delay
  logic [31:0] t = 32'h9599_9604; // shadow of the timing register
  logic [31:0] d;                 // last read value
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          fq[7] = '{2, 0, 1, 0, 1, 2, 2};       // freq select
  int          cd[7] = '{0, 0, 0, 2, 2, 2, 1};       // refresh code
  int          nn[7] = '{15, 10, 12, 16, 20, 26, 21}; // expected wait

  dtt_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sch_rd_i(s_rd), .sch_wr_i(s_wr), .sch_ref_i(s_ref), .sch_new_rank_i(s_nr),
    .rd_ok_o(rd_ok_o), .wr_ok_o(wr_ok_o), .ref_busy_o(ref_busy_o),
    .rdptr_dly_o(rdptr_dly_o));
  dtt_sched_model i_sch (.clk_i(clk_i), .sch_rd_o(s_rd), .sch_wr_o(s_wr),
    .sch_ref_o(s_ref), .new_rank_o(s_nr));

  // clock and hang guard; whole run is well under a thousand cycles
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // single-cycle write, strobe released at the sampling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // write then read with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // only defined codes go in, so the shadow stays legal
  task automatic setf(input int lsb, input logic [1:0] c);
    t[lsb+:2] = c;
    wr(8'h78, t);
  endtask
  // issue a command and count cycles its grant stays deasserted (or busy stays asserted)
  task automatic gap(input logic [1:0] k, input logic nr, input int s, input int n);
    int m;
    m = 0;
    @(posedge clk_i);
    i_sch.issue(k, nr);
    // first look is just after the edge that takes the command
    for (int i = 0; i < 40; i++) begin
      #1;
      if ((s == 0 ? rd_ok_o : s == 1 ? wr_ok_o : !ref_busy_o) !== 1'b0) break;
      m++;
      @(posedge clk_i);
    end
    chk(32'(m), 32'(n));
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h78);
    chk(d, 32'h9599_9604);
    chk({30'h0, rdptr_dly_o}, 32'h2);
    wr_rd(8'h78, 32'h5A5A_A5A5);
    chk(d, 32'h5A5A_A5A5);
    rd(8'h40);
    chk(d, 32'h0);
    wr(8'h78, t);
    $display("register access done");
    for (int c = 0; c < 3; c++) begin
      setf(30, 2'(c));
      repeat (2) @(posedge clk_i);
      #1 chk({30'h0, rdptr_dly_o}, 32'(c));
    end
    $display("read pointer delay done");
    for (int c = 0; c < 4; c++) begin
      setf(26, 2'(c));
      gap(2'h0, 1'b0, 1, c + 1);
    end
    for (int c = 1; c < 4; c++) begin
      setf(28, 2'(c));
      gap(2'h1, 1'b1, 0, c);
      setf(24, 2'(c));
      gap(2'h0, 1'b1, 0, c);
    end
    $display("turnaround gaps done");
    // wrrd and rdrd codes 11 are only legal at 200 MHz, so step back before slower clocks
    setf(28, 2'h1);
    setf(24, 2'h1);
    for (int i = 0; i < 7; i++) begin
      wr(8'h7C, 32'(fq[i]));
      setf(22, 2'(cd[i]));
      gap(2'h2, 1'b0, 2, nn[i]);
    end
    $display("refresh cycle time done");
    // frequency code 3 is refused, the 200 MHz setting stays
    wr(8'h7C, 32'h3);
    rd(8'h7C);
    chk(d, 32'h2);
    rd(8'h80);
    chk(d, 32'h0);
    $display("frequency and status done");
    test_done();
  end
endmodule
